// ---- logic/dofs_pkg.sv ----
// Package for the digital output function select block
`default_nettype none
package dofs_pkg;
  // ********************************************************************
  // Parameter indices and reset values
  // ********************************************************************
  localparam logic [15:0] DOFS_IDX_OUT1 = 16'h2410;
  localparam logic [15:0] DOFS_IDX_OUT2 = 16'h2411;
  localparam logic [15:0] DOFS_IDX_OUT3 = 16'h2412;
  localparam logic [7:0] DOFS_RST_OUT1 = 8'h01;
  localparam logic [7:0] DOFS_RST_OUT2 = 8'h03;
  localparam logic [7:0] DOFS_RST_OUT3 = 8'h04;
  // ********************************************************************
  // Selection field layout
  // ********************************************************************
  localparam int DOFS_POL_BIT = 7;
  localparam int DOFS_FID_W = 7;
  localparam logic [7:0] DOFS_SEL_HOST = 8'h00;
  // Host digital-output object, bit of output one
  localparam int DOFS_HOST_BIT0 = 16;
  localparam int DOFS_NUM_OUT = 3;

  typedef struct packed {
    logic wr;
    logic [15:0] idx;
    logic [7:0] data;
  } dofs_par_req_s;
endpackage
`default_nettype wire

// ---- logic/dofs_top.sv ----
// Digital output function select: selectors and output drivers
`timescale 1ns/100ps
`default_nettype none
module dofs_top
  import dofs_pkg::*;
#(
  parameter int NUM_FUNC = 128
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire dofs_par_req_s par_req,
  input wire logic [15:0] par_rd_idx,
  output logic [7:0] par_rd_data,
  input wire logic [NUM_FUNC-1:0] func_status,
  input wire logic [31:0] host_do_obj,
  output logic digital_output_one,
  output logic digital_output_two,
  output logic digital_output_three
);
  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (NUM_FUNC < 1 || NUM_FUNC > (1 << DOFS_FID_W))
  begin : g_bad_width
    $error("NUM_FUNC out of range");
  end

  // ********************************************************************
  // Selector registers
  // ********************************************************************
  logic [7:0] sel_q [DOFS_NUM_OUT];
  logic [DOFS_NUM_OUT-1:0] out_q;
  logic [DOFS_NUM_OUT-1:0] out_d;

  // Unlisted indices are ignored; a restart is never needed
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sel_q[0] <= DOFS_RST_OUT1;
      sel_q[1] <= DOFS_RST_OUT2;
      sel_q[2] <= DOFS_RST_OUT3;
    end
    else if (par_req.wr)
    begin
      case (par_req.idx)
        DOFS_IDX_OUT1: sel_q[0] <= par_req.data;
        DOFS_IDX_OUT2: sel_q[1] <= par_req.data;
        DOFS_IDX_OUT3: sel_q[2] <= par_req.data;
        default: ;
      endcase
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      par_rd_data <= 8'h00;
    else
    begin
      case (par_rd_idx)
        DOFS_IDX_OUT1: par_rd_data <= sel_q[0];
        DOFS_IDX_OUT2: par_rd_data <= sel_q[1];
        DOFS_IDX_OUT3: par_rd_data <= sel_q[2];
        default: par_rd_data <= 8'h00;
      endcase
    end
  end

  // ********************************************************************
  // Output decode
  // ********************************************************************
  // Codes beyond NUM_FUNC read as inactive; the host must avoid them
  function automatic logic drive_level(input logic [7:0] sel,
                                       input logic [NUM_FUNC-1:0] st,
                                       input logic host_bit);
    logic [DOFS_FID_W-1:0] fid;
    logic act;
    fid = sel[DOFS_FID_W-1:0];
    act = (int'(fid) < NUM_FUNC) ? st[fid] : 1'b0;
    if (sel == DOFS_SEL_HOST)
      drive_level = host_bit;
    else if (sel[DOFS_POL_BIT])
      drive_level = act;
    else
      drive_level = ~act;
  endfunction

  for (genvar i = 0; i < DOFS_NUM_OUT; i++)
  begin : g_out
    always_comb
    begin
      out_d[i] = drive_level(sel_q[i], func_status,
                             host_do_obj[DOFS_HOST_BIT0 + i]);
    end
  end

  // Outputs idle inactive (high, normally open) during reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      out_q <= '1;
    else
      out_q <= out_d;
  end

  assign digital_output_one = out_q[0];
  assign digital_output_two = out_q[1];
  assign digital_output_three = out_q[2];

  // ********************************************************************
  // Assertions
  // ********************************************************************
  logic [DOFS_FID_W-1:0] fid1;
  assign fid1 = sel_q[0][DOFS_FID_W-1:0];

  chk_no_active_low: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[0] != DOFS_SEL_HOST && !sel_q[0][DOFS_POL_BIT]
     && int'(fid1) < NUM_FUNC && func_status[fid1])
    |=> !digital_output_one)
    else $error("normally-open output not low while active");

  chk_nc_active_high: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[0][DOFS_POL_BIT] && int'(fid1) < NUM_FUNC
     && func_status[fid1])
    |=> digital_output_one)
    else $error("normally-close output not high while active");

  chk_host_pass: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[2] == DOFS_SEL_HOST)
    |=> digital_output_three == $past(host_do_obj[DOFS_HOST_BIT0 + 2]))
    else $error("output three not following host bit 18");

  chk_sel_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    (par_req.wr && par_req.idx == DOFS_IDX_OUT2)
    |=> sel_q[1] == $past(par_req.data) ##1
        ($past(par_rd_idx) != DOFS_IDX_OUT2
         || par_rd_data == $past(sel_q[1])))
    else $error("selector two write not taken");

  chk_immediate: assert property (
    @(posedge mclk) disable iff (!nrst)
    (par_req.wr && par_req.idx == DOFS_IDX_OUT2
     && par_req.data != DOFS_SEL_HOST)
    |=> ##1 digital_output_two ==
        ($past(par_req.data[DOFS_POL_BIT], 2) ~^
         ((($past(func_status) >> $past(par_req.data[DOFS_FID_W-1:0], 2))
           & NUM_FUNC'(1)) != '0)))
    else $error("new selector not applied within two cycles");

  // Function state per output, worked out apart from the decode
  // function so that the checks below do not lean on it
  logic [DOFS_NUM_OUT-1:0] fn_on;
  always_comb
  begin
    fn_on = '0;
    for (int i = 0; i < DOFS_NUM_OUT; i++)
    begin
      if (int'(sel_q[i][DOFS_FID_W-1:0]) < NUM_FUNC)
        fn_on[i] = func_status[sel_q[i][DOFS_FID_W-1:0]];
    end
  end

  // No disable here: this one watches the reset itself
  chk_reset_defaults: assert property (
    @(posedge mclk)
    !nrst
    |=> sel_q[0] == DOFS_RST_OUT1 && sel_q[1] == DOFS_RST_OUT2
        && sel_q[2] == DOFS_RST_OUT3 && out_q == '1
        && par_rd_data == 8'h00)
    else $error("reset did not restore selectors and pins");

  chk_no_idle_high: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[0] != DOFS_SEL_HOST && !sel_q[0][DOFS_POL_BIT] && !fn_on[0])
    |=> digital_output_one)
    else $error("normally-open output not high while idle");

  chk_nc_three: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[2][DOFS_POL_BIT] && fn_on[2])
    |=> digital_output_three)
    else $error("normally-close output three not high while active");

  chk_nc_idle_low: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[2][DOFS_POL_BIT] && !fn_on[2])
    |=> !digital_output_three)
    else $error("normally-close output three not low while idle");

  chk_host_one: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[0] == DOFS_SEL_HOST)
    |=> digital_output_one == $past(host_do_obj[DOFS_HOST_BIT0]))
    else $error("output one not following host bit 16");

  chk_host_two: assert property (
    @(posedge mclk) disable iff (!nrst)
    (sel_q[1] == DOFS_SEL_HOST)
    |=> digital_output_two == $past(host_do_obj[DOFS_HOST_BIT0 + 1]))
    else $error("output two not following host bit 17");

  // A stray index must leave every selector alone
  chk_stray_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    (par_req.wr && par_req.idx != DOFS_IDX_OUT1
     && par_req.idx != DOFS_IDX_OUT2 && par_req.idx != DOFS_IDX_OUT3)
    |=> $stable(sel_q[0]) && $stable(sel_q[1]) && $stable(sel_q[2]))
    else $error("unlisted index changed a selector");

  chk_read_one: assert property (
    @(posedge mclk) disable iff (!nrst)
    (par_rd_idx == DOFS_IDX_OUT1)
    |=> par_rd_data == $past(sel_q[0]))
    else $error("selector one read-back wrong");

  cov_host_mode: cover property (@(posedge mclk) disable iff (!nrst)
    sel_q[0] == DOFS_SEL_HOST && host_do_obj[DOFS_HOST_BIT0]);
  cov_nc_mode: cover property (@(posedge mclk) disable iff (!nrst)
    sel_q[1][DOFS_POL_BIT] ##1 digital_output_two);
  cov_no_low: cover property (@(posedge mclk) disable iff (!nrst)
    !digital_output_three && sel_q[2] != DOFS_SEL_HOST);
  cov_nc_one: cover property (@(posedge mclk) disable iff (!nrst)
    sel_q[0][DOFS_POL_BIT] && fn_on[0]);
endmodule
`default_nettype wire

// ---- test/dofs_host.sv ----
// Host controller model driving selectors, host object and status lines
`timescale 1ns/100ps
`default_nettype none
module dofs_host
  import dofs_pkg::*;
(
  input wire logic mclk,
  output dofs_par_req_s par_req,
  output logic [127:0] func_status,
  output logic [31:0] host_do_obj
);
  initial
  begin
    par_req = '0;
    func_status = '0;
    host_do_obj = '0;
  end
  // Callers may pass an unlisted index (t_host writes 16'h2413); the device ignores such writes
  task automatic wr_sel(input logic [15:0] idx, input logic [7:0] v);
    par_req = '{1'b1, idx, v};
    @(negedge mclk);
    par_req.wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic set_in(input logic [127:0] fs, input logic [31:0] ob);
    func_status = fs;
    host_do_obj = ob;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- test/dofs_top_test.sv ----
// Self-checking bench for the output function select block
`timescale 1ns/100ps
`default_nettype none
module dofs_top_test;
  import dofs_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] par_rd_idx = 16'h0000;
  dofs_par_req_s par_req;
  logic [7:0] par_rd_data;
  logic [127:0] func_status;
  logic [31:0] host_do_obj;
  logic [2:0] pins;
  int num_errors = 0;
  int total_checks = 0;
  dofs_host dofs_host_inst (.mclk(mclk), .par_req(par_req),
    .func_status(func_status), .host_do_obj(host_do_obj));
  dofs_top #(.NUM_FUNC(128)) dofs_top_inst (.mclk(mclk), .nrst(nrst),
    .par_req(par_req), .par_rd_idx(par_rd_idx), .par_rd_data(par_rd_data),
    .func_status(func_status), .host_do_obj(host_do_obj),
    .digital_output_one(pins[0]), .digital_output_two(pins[1]),
    .digital_output_three(pins[2]));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    par_rd_idx = idx;
    @(negedge mclk);
    chk(par_rd_data, exp);
  endtask
  task automatic t_reset();
    rd(DOFS_IDX_OUT1, 8'h01);
    rd(DOFS_IDX_OUT2, 8'h03);
    rd(DOFS_IDX_OUT3, 8'h04);
    rd(16'h2413, 8'h00);
    chk({5'h00, pins}, 8'h07);
  endtask
  task automatic t_pol();
    dofs_host_inst.wr_sel(DOFS_IDX_OUT1, 8'h01);
    dofs_host_inst.wr_sel(DOFS_IDX_OUT2, 8'h83);
    dofs_host_inst.wr_sel(DOFS_IDX_OUT3, 8'h95);
    dofs_host_inst.set_in(128'h0020_000A, 32'h0000_0000);
    chk({5'h00, pins}, 8'h06);
    dofs_host_inst.set_in(128'h0, 32'h0007_0000);
    chk({5'h00, pins}, 8'h01);
    dofs_host_inst.set_in(128'h8, 32'h0000_0000);
    chk({5'h00, pins}, 8'h03);
    dofs_host_inst.wr_sel(DOFS_IDX_OUT1, 8'h81);
    dofs_host_inst.set_in(128'h2, 32'h0000_0000);
    chk({5'h00, pins}, 8'h01);
    dofs_host_inst.set_in(128'h0, 32'h0000_0000);
    chk({5'h00, pins}, 8'h00);
  endtask
  // Neighbouring host bits are set to catch an off-by-one bit mapping
  task automatic t_host();
    dofs_host_inst.wr_sel(DOFS_IDX_OUT1, 8'h00);
    dofs_host_inst.wr_sel(DOFS_IDX_OUT2, 8'h00);
    dofs_host_inst.wr_sel(DOFS_IDX_OUT3, 8'h00);
    dofs_host_inst.wr_sel(16'h2413, 8'h81);
    for (int v = 0; v < 8; v++)
    begin
      dofs_host_inst.set_in('1, 32'h0008_8000 | (32'(v) << 16));
      chk({5'h00, pins}, 8'(v));
    end
    rd(DOFS_IDX_OUT1, 8'h00);
  endtask
  // A reset in mid-run must restore the default selectors
  task automatic t_rst2();
    nrst = 1'b0;
    @(negedge mclk);
    chk({5'h00, pins}, 8'h07);
    nrst = 1'b1;
    rd(DOFS_IDX_OUT2, 8'h03);
    chk({5'h00, pins}, 8'h00);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_pol();
    t_host();
    t_rst2();
    give_verdict();
  end
endmodule
`default_nettype wire
